// [inc/ropat_pkg.sv]
package ropat_pkg;

    // clock and time base
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_US = 50;
    localparam int unsigned TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

    // group geometry: blocks 0/1 source, 2/3 sink
    localparam int NPTS = 16;
    localparam int NBLK = 4;
    localparam logic [3:0] PT_LAST = 4'hF;
    localparam logic [1:0] BLK_SRC0 = 2'h0;
    localparam logic [1:0] BLK_SRC1 = 2'h1;
    localparam logic [1:0] BLK_SNK0 = 2'h2;
    localparam logic [1:0] BLK_SNK1 = 2'h3;

    // pulse times in microseconds as printed
    localparam int unsigned W32_US = 1000;
    localparam int unsigned WOFF_FIRST_US = 1700;
    localparam int unsigned WOFF_MAX_US = 20000;
    localparam int unsigned WOFF_STEP_US = 3050;
    localparam int unsigned WON_FIRST_US = 5000;
    localparam int unsigned WON_SECOND_US = 7500;
    localparam int unsigned GAP_US = 10000;

    // same times in ticks
    localparam logic [8:0] T_32 = 9'(W32_US / TICK_US);
    localparam logic [8:0] T_OFF_FIRST = 9'((WOFF_FIRST_US + TICK_US - 1) / TICK_US);
    localparam logic [8:0] T_OFF_MAX = 9'(WOFF_MAX_US / TICK_US);
    localparam logic [8:0] T_OFF_STEP = 9'(WOFF_STEP_US / TICK_US);
    localparam logic [8:0] T_ON_FIRST = 9'(WON_FIRST_US / TICK_US);
    localparam logic [8:0] T_ON_SECOND = 9'(WON_SECOND_US / TICK_US);
    localparam logic [8:0] T_GAP = 9'(GAP_US / TICK_US);
    localparam logic [8:0] T_ONE = 9'h001;

    // pulse count limits
    localparam logic [2:0] MAX_PULSES_OFF = 3'h7;
    localparam logic [2:0] MAX_PULSES_ON = 3'h2;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_CHECK = 7'h02,
        ST_SEL   = 7'h04,
        ST_PULSE = 7'h08,
        ST_GAP   = 7'h10,
        ST_NEXT  = 7'h20,
        ST_DONE  = 7'h40
    } ropat_state_t;

endpackage : ropat_pkg

// [rtl/ropat_tick.sv]
`timescale 1ns/1ps
module ropat_tick
    import ropat_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // time base
    output logic o_tick
);
    typedef struct packed {
        logic [11:0] cnt;
        logic tick;
    } ropat_tick_t;

    ropat_tick_t s_reg;
    ropat_tick_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = (s_reg.cnt == TICK_LAST);
        s_next.cnt = s_next.tick ? 12'h000 : s_reg.cnt + 12'h001;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_tick = s_reg.tick;

endmodule : ropat_tick

// [rtl/ropat_nl_merge.sv]
`timescale 1ns/1ps
module ropat_nl_merge
    import ropat_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // point state and per-block no-load flags
    input wire logic [NPTS-1:0] i_point_on,
    input wire logic [NBLK-1:0][NPTS-1:0] i_nl,
    // merged report
    output logic [NPTS-1:0] o_nl_fault,
    output logic [NPTS-1:0][1:0] o_nl_loc
);
    typedef struct packed {
        logic [NBLK-1:0][NPTS-1:0] prev;
        logic [NPTS-1:0] fault;
        logic [NPTS-1:0][1:0] loc;
    } ropat_nl_t;

    ropat_nl_t s_reg;
    ropat_nl_t s_next;
    logic [NPTS-1:0] fault_w;
    logic [NPTS-1:0][1:0] loc_w;

    genvar g;
    generate
        for (g = 0; g < NPTS; g++) begin : g_pt
            logic src_both;
            logic snk_both;
            logic [1:0] src_loc;
            logic [1:0] snk_loc;
            assign src_both = i_nl[0][g] & i_nl[1][g];
            assign snk_both = i_nl[2][g] & i_nl[3][g];
            // the block whose flag arrived last names the fault
            assign src_loc = (s_reg.prev[0][g] & ~s_reg.prev[1][g]) ? BLK_SRC1 :
                             (s_reg.prev[1][g] & ~s_reg.prev[0][g]) ? BLK_SRC0 :
                             (s_reg.prev[0][g] & s_reg.fault[g]) ? s_reg.loc[g] : BLK_SRC1;
            assign snk_loc = (s_reg.prev[2][g] & ~s_reg.prev[3][g]) ? BLK_SNK1 :
                             (s_reg.prev[3][g] & ~s_reg.prev[2][g]) ? BLK_SNK0 :
                             (s_reg.prev[2][g] & s_reg.fault[g]) ? s_reg.loc[g] : BLK_SNK1;
            always_comb begin
                if (!i_point_on[g]) begin
                    fault_w[g] = |{i_nl[3][g], i_nl[2][g], i_nl[1][g], i_nl[0][g]}; // [R13]
                    loc_w[g] = i_nl[0][g] ? BLK_SRC0 : i_nl[1][g] ? BLK_SRC1 :
                               i_nl[2][g] ? BLK_SNK0 : BLK_SNK1;
                end else begin
                    fault_w[g] = src_both | snk_both; // [R14]
                    loc_w[g] = src_both ? src_loc : snk_loc; // [R15]
                end
            end
        end
    endgenerate

    always_comb begin
        s_next = s_reg;
        s_next.prev = i_nl;
        s_next.fault = fault_w;
        s_next.loc = loc_w;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_nl_fault = s_reg.fault;
    assign o_nl_loc = s_reg.loc;

    on_pair_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R14]
        (i_point_on[0] && !(i_nl[0][0] && i_nl[1][0]) && !(i_nl[2][0] && i_nl[3][0]))
        |=> !o_nl_fault[0])
        else $error("no-load fault on lit point without a full pair");

endmodule : ropat_nl_merge

// [rtl/ropat_top.sv]
// Functional notes
// (R1) shut group down on lost block or fault that could block trip-off
// (R2) start test only with all blocks online and no block override
// (R3) every point unforced, fault-free, same state on all blocks
// (R4) lit points get on-off-on, dark points get off-on-off
// (R5) 32-circuit blocks use pulses of about one millisecond
// (R6) 16-circuit off-on-off starts with 1.7 ms pulse, samples current
// (R7) check feedback after each pulse; wrong lengthens and repeats, right stops
// (R8) off-on-off at most seven pulses, 1.7 ms to 20 ms wide
// (R9) wait about 5 to 15 ms before pulsing the same point again
// (R10) on-off-on first drives off 5 ms, checks only voltage feedback
// (R11) wrong voltage gives one more 7.5 ms off pulse, two at most
// (R12) block that lost all controllers drives its default state
// (R13) outputs off: any one block's no-load reports a fault
// (R14) outputs on: fault only when both sources or both sinks report
// (R15) paired fault carries location of the second reporting block
// (R16) load lit only with a source and a sink output on
// (R17) all four blocks share one output address and the same data
// (R18) blocks sharing a bus have distinct serial addresses
// (R19) manual trip forces alarm state, manual override holds normal state
// (R20) controllers should not call the pulse test themselves in redundant mode
// (R21) outputs changing during a test give no result and no fault
// (R22) unmet precondition skips the group with no pass or fail
`timescale 1ns/1ps
module ropat_top
    import ropat_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // group status
    input wire logic [NBLK-1:0] i_blk_online,
    input wire logic [NBLK-1:0] i_blk_override,
    input wire logic [NBLK-1:0] i_blk_comm_lost,
    input wire logic [NBLK-1:0][NPTS-1:0] i_blk_state,
    input wire logic [NBLK-1:0][NPTS-1:0] i_blk_noload,
    // configuration
    input wire logic i_is_32ckt,
    input wire logic i_noload_en,
    input wire logic [NPTS-1:0] i_norm_energized,
    input wire logic [NPTS-1:0] i_default_state,
    // shared output data and point controls
    input wire logic [NPTS-1:0] i_out_cmd,
    input wire logic [NPTS-1:0] i_force,
    input wire logic [NPTS-1:0] i_hw_fault,
    input wire logic [NPTS-1:0] i_manual_trip,
    input wire logic [NPTS-1:0] i_manual_ovr,
    // point feedback
    input wire logic [NPTS-1:0] i_volt_fb,
    input wire logic [NPTS-1:0] i_cur_ok,
    // test control
    input wire logic i_test_start,
    input wire logic i_fault_clr,
    // block drives and load state
    output logic [NBLK-1:0][NPTS-1:0] o_blk_out,
    output logic [NPTS-1:0] o_load_on,
    // test status
    output logic o_busy,
    output logic o_skip,
    output logic o_pass,
    output logic o_fail,
    output logic [NPTS-1:0] o_fault_mask,
    output logic o_shutdown,
    // no-load report
    output logic [NPTS-1:0] o_nl_fault,
    output logic [NPTS-1:0][1:0] o_nl_loc
);
    typedef struct packed {
        ropat_state_t st;
        logic [3:0] pt;
        logic mode;
        logic [2:0] pcnt;
        logic [8:0] width;
        logic [8:0] tcnt;
        logic cur_seen;
        logic aborted;
        logic [NPTS-1:0] cmd_snap;
        logic [NPTS-1:0] fail_mask;
        logic trip_latch;
        logic [NBLK-1:0][NPTS-1:0] blk_out;
        logic [NPTS-1:0] load_on;
        logic shutdown;
        logic busy;
        logic skip;
        logic pass;
        logic fail;
        logic [NPTS-1:0] fault_mask;
    } ropat_main_t;

    ropat_main_t s_reg;
    ropat_main_t s_next;
    logic tick;
    logic group_ok;
    logic points_ok;
    logic cmd_moved;
    logic fb_ok;
    logic [2:0] pmax;
    logic [8:0] wider;
    logic [NPTS-1:0] point_val;
    logic [NPTS-1:0] same_state;
    logic [NPTS-1:0] point_on;

    ropat_tick u_tick (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .o_tick(tick)
    );

    ropat_nl_merge u_nl (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_point_on(point_on),
        .i_nl(i_blk_noload),
        .o_nl_fault(o_nl_fault),
        .o_nl_loc(o_nl_loc)
    );

    genvar g;
    generate
        for (g = 0; g < NPTS; g++) begin : g_pt
            // matching circuit on every block in the same state
            assign same_state[g] = (i_blk_state[0][g] == i_blk_state[1][g]) &&
                                   (i_blk_state[0][g] == i_blk_state[2][g]) &&
                                   (i_blk_state[0][g] == i_blk_state[3][g]); // [R3]
            // manual trip wins over override, both over the voted command
            always_comb begin
                if (i_manual_trip[g]) begin
                    point_val[g] = ~i_norm_energized[g]; // [R19]
                end else if (i_manual_ovr[g]) begin
                    point_val[g] = i_norm_energized[g]; // [R19]
                end else if (s_reg.busy && (s_reg.st == ST_PULSE) && (s_reg.pt == 4'(g))) begin
                    point_val[g] = ~s_reg.mode; // [R4]
                end else begin
                    point_val[g] = i_out_cmd[g]; // [R17]
                end
            end
        end
    endgenerate

    assign point_on = s_reg.blk_out[0] | s_reg.blk_out[1];
    assign group_ok = (&i_blk_online) && !(|i_blk_override); // [R2]
    assign points_ok = !(|i_force) && !(|i_hw_fault) && (&same_state); // [R3]
    assign cmd_moved = (i_out_cmd != s_reg.cmd_snap);
    assign pmax = s_reg.mode ? MAX_PULSES_ON : MAX_PULSES_OFF;
    // lit points check voltage only; dark points also need current when enabled
    assign fb_ok = (i_volt_fb[s_reg.pt] == ~s_reg.mode) &&
                   (s_reg.mode || !i_noload_en || s_reg.cur_seen || i_cur_ok[s_reg.pt]); // [R7] [R10]
    assign wider = ((s_reg.width + T_OFF_STEP) > T_OFF_MAX) ? T_OFF_MAX :
                   s_reg.width + T_OFF_STEP; // [R8]

    always_comb begin
        s_next = s_reg;
        s_next.skip = 1'b0;
        s_next.pass = 1'b0;
        s_next.fail = 1'b0;
        unique case (s_reg.st)
            ST_IDLE: begin
                if (i_test_start) begin
                    s_next.st = ST_CHECK;
                    s_next.busy = 1'b1;
                end
            end
            ST_CHECK: begin
                if (group_ok && points_ok) begin
                    s_next.st = ST_SEL;
                    s_next.cmd_snap = i_out_cmd;
                    s_next.pt = 4'h0;
                    s_next.fail_mask = '0;
                    s_next.aborted = 1'b0;
                end else begin
                    s_next.st = ST_IDLE; // [R22]
                    s_next.busy = 1'b0;
                    s_next.skip = 1'b1;
                end
            end
            ST_SEL: begin
                s_next.mode = s_reg.cmd_snap[s_reg.pt]; // [R4]
                s_next.pcnt = 3'h0;
                s_next.cur_seen = 1'b0;
                if (i_is_32ckt) begin
                    s_next.width = T_32; // [R5]
                end else if (s_reg.cmd_snap[s_reg.pt]) begin
                    s_next.width = T_ON_FIRST; // [R10]
                end else begin
                    s_next.width = T_OFF_FIRST; // [R6]
                end
                s_next.tcnt = s_next.width;
                s_next.st = cmd_moved ? ST_DONE : ST_PULSE;
                s_next.aborted = cmd_moved; // [R21]
            end
            ST_PULSE: begin
                if (!s_reg.mode && i_noload_en && i_cur_ok[s_reg.pt]) begin
                    s_next.cur_seen = 1'b1; // [R6]
                end
                if (cmd_moved) begin
                    s_next.st = ST_DONE; // [R21]
                    s_next.aborted = 1'b1;
                end else if (tick) begin
                    if (s_reg.tcnt > T_ONE) begin
                        s_next.tcnt = s_reg.tcnt - T_ONE;
                    end else begin
                        s_next.pcnt = s_reg.pcnt + 3'h1;
                        if (fb_ok) begin
                            s_next.st = ST_NEXT; // [R7]
                        end else if (s_next.pcnt == pmax) begin
                            s_next.st = ST_NEXT; // [R8] [R11]
                            s_next.fail_mask[s_reg.pt] = 1'b1;
                        end else begin
                            s_next.st = ST_GAP;
                            s_next.tcnt = T_GAP; // [R9]
                            s_next.cur_seen = 1'b0;
                            if (i_is_32ckt) begin
                                s_next.width = T_32; // [R5]
                            end else if (s_reg.mode) begin
                                s_next.width = T_ON_SECOND; // [R11]
                            end else begin
                                s_next.width = wider; // [R7]
                            end
                        end
                    end
                end
            end
            ST_GAP: begin
                if (cmd_moved) begin
                    s_next.st = ST_DONE; // [R21]
                    s_next.aborted = 1'b1;
                end else if (tick) begin
                    if (s_reg.tcnt > T_ONE) begin
                        s_next.tcnt = s_reg.tcnt - T_ONE;
                    end else begin
                        s_next.tcnt = s_reg.width;
                        s_next.st = ST_PULSE; // [R9]
                    end
                end
            end
            ST_NEXT: begin
                if (s_reg.pt == PT_LAST) begin
                    s_next.st = ST_DONE;
                end else begin
                    s_next.pt = s_reg.pt + 4'h1;
                    s_next.st = ST_SEL;
                end
            end
            ST_DONE: begin
                s_next.st = ST_IDLE;
                s_next.busy = 1'b0;
                if (!s_reg.aborted) begin
                    s_next.pass = !(|s_reg.fail_mask);
                    s_next.fail = |s_reg.fail_mask;
                    s_next.fault_mask = s_reg.fail_mask;
                    if (|(s_reg.fail_mask & i_norm_energized)) begin
                        s_next.trip_latch = 1'b1; // [R1]
                    end
                end
            end
            default: begin
                s_next.st = ST_IDLE;
                s_next.busy = 1'b0;
            end
        endcase
        // a new trip fault in the clearing cycle still latches
        if (i_fault_clr && !(s_reg.st == ST_DONE && !s_reg.aborted &&
                             |(s_reg.fail_mask & i_norm_energized))) begin
            s_next.trip_latch = 1'b0;
        end
        s_next.shutdown = !(&i_blk_online) || s_next.trip_latch; // [R1]
        for (int b = 0; b < NBLK; b++) begin
            s_next.blk_out[b] = i_blk_comm_lost[b] ? i_default_state : point_val; // [R12]
        end
        s_next.load_on = (s_next.blk_out[0] | s_next.blk_out[1]) &
                         (s_next.blk_out[2] | s_next.blk_out[3]); // [R16]
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s_reg <= '{st: ST_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_blk_out = s_reg.blk_out;
    assign o_load_on = s_reg.load_on;
    assign o_busy = s_reg.busy;
    assign o_skip = s_reg.skip;
    assign o_pass = s_reg.pass;
    assign o_fail = s_reg.fail;
    assign o_fault_mask = s_reg.fault_mask;
    assign o_shutdown = s_reg.shutdown;

    sequence moved_in_test_s;
        (s_reg.st == ST_PULSE) && cmd_moved;
    endsequence

    sequence quiet_end_s;
        (s_reg.st == ST_DONE) ##1 (!o_pass && !o_fail);
    endsequence

    abort_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R21]
        moved_in_test_s |=> quiet_end_s)
        else $error("changed outputs during test still gave a result");

    skip_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R2]
        (s_reg.st == ST_CHECK && !(&i_blk_online)) |=> (o_skip && !o_busy) ##1 !o_pass)
        else $error("test ran with a block offline");

    skip_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R22]
        o_skip |-> !o_pass && !o_fail && (s_reg.st == ST_IDLE))
        else $error("skipped group produced a result");

    offline_shut_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R1]
        !(&i_blk_online) |=> o_shutdown)
        else $error("no shutdown after block loss");

    comm_default_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R12]
        i_blk_comm_lost[3] |=> (o_blk_out[3] == $past(i_default_state)))
        else $error("lost block not at default state");

    load_pair_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R16]
        o_load_on == ((o_blk_out[0] | o_blk_out[1]) & (o_blk_out[2] | o_blk_out[3])))
        else $error("load state disagrees with source and sink drives");

    pulse_count_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R8]
        (s_reg.st == ST_PULSE) |-> (s_reg.pcnt < pmax) && (s_reg.width <= T_OFF_MAX))
        else $error("pulse count or width over limit");

    on_width_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R11]
        (s_reg.st == ST_PULSE && s_reg.mode && !i_is_32ckt) |->
        ((s_reg.pcnt == 3'h0 && s_reg.width == T_ON_FIRST) ||
         (s_reg.pcnt == 3'h1 && s_reg.width == T_ON_SECOND)))
        else $error("on-off-on pulse width wrong");

    trip_force_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R19]
        (i_manual_trip[0] && !i_blk_comm_lost[0]) |=>
        (o_blk_out[0][0] != $past(i_norm_energized[0])))
        else $error("manual trip did not force alarm state");

    ovr_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R19]
        (i_manual_ovr[0] && !i_manual_trip[0] && !i_blk_comm_lost[0]) |=>
        (o_blk_out[0][0] == $past(i_norm_energized[0])))
        else $error("manual override did not hold normal state");

    point_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R3]
        (s_reg.st == ST_CHECK && !points_ok) |=> o_skip)
        else $error("test ran with a forced, faulty or split point");

    lit_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R10]
        (s_reg.st == ST_PULSE && s_reg.mode && !i_blk_comm_lost[0] &&
         !i_manual_trip[s_reg.pt] && !i_manual_ovr[s_reg.pt]) |=> !o_blk_out[0][s_reg.pt])
        else $error("on-off-on pulse did not drive the point off");

endmodule : ropat_top

// [verif/ropat_field_model.sv]
`timescale 1ns/1ps
module ropat_field_model
    import ropat_pkg::*;
(
    // load state seen in the field
    input wire logic [NPTS-1:0] i_load_on,
    input wire logic [NPTS-1:0] i_open_load,
    // point feedback to the group
    output logic [NPTS-1:0] o_volt_fb,
    output logic [NPTS-1:0] o_cur_ok
);
    // only the group load state is driven
    // load sees voltage only with a source and a sink conducting
    assign o_volt_fb = i_load_on;
    // an open load never draws current
    assign o_cur_ok = i_load_on & ~i_open_load;
endmodule : ropat_field_model

// [verif/redundant_output_pulse_autotest_tb_top.sv]
`timescale 1ns/1ps
module redundant_output_pulse_autotest_tb_top;
    import ropat_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [NBLK-1:0] i_blk_online = 4'hF;
    logic [NBLK-1:0] i_blk_override = 4'h0;
    logic [NBLK-1:0] i_blk_comm_lost = 4'h0;
    logic [NBLK-1:0][NPTS-1:0] i_blk_state = 64'h0;
    logic [NBLK-1:0][NPTS-1:0] i_blk_noload = 64'h0;
    logic i_is_32ckt = 1'b1;
    logic i_noload_en = 1'b1;
    logic i_test_start = 1'b0;
    logic i_fault_clr = 1'b0;
    logic [NPTS-1:0] i_norm_energized = 16'h0000;
    logic [NPTS-1:0] i_default_state = 16'h0000;
    logic [NPTS-1:0] i_out_cmd = 16'h0000;
    logic [NPTS-1:0] i_force = 16'h0000;
    logic [NPTS-1:0] i_hw_fault = 16'h0000;
    logic [NPTS-1:0] i_manual_trip = 16'h0000;
    logic [NPTS-1:0] i_manual_ovr = 16'h0000;
    logic [NPTS-1:0] i_volt_fb, i_cur_ok, o_load_on, o_fault_mask, o_nl_fault;
    logic [NBLK-1:0][NPTS-1:0] o_blk_out;
    logic [NPTS-1:0][1:0] o_nl_loc;
    logic o_busy, o_skip, o_pass, o_fail, o_shutdown, f;
    logic saw_done = 1'b0;
    logic [63:0] e;
    logic [3:0] m, m2;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int n, p, q;

    ropat_top ropat_top_i (
        .i_ref_clk, .i_rst_n, .i_blk_online, .i_blk_override, .i_blk_comm_lost, .i_blk_state,
        .i_blk_noload, .i_is_32ckt, .i_noload_en, .i_norm_energized, .i_default_state, .i_out_cmd,
        .i_force, .i_hw_fault, .i_manual_trip, .i_manual_ovr, .i_volt_fb, .i_cur_ok,
        .i_test_start, .i_fault_clr, .o_blk_out, .o_load_on, .o_busy, .o_skip, .o_pass, .o_fail,
        .o_fault_mask, .o_shutdown, .o_nl_fault, .o_nl_loc
    );
    ropat_field_model ropat_field_model_i (
        .i_load_on(o_load_on), .i_open_load(16'h0000), .o_volt_fb(i_volt_fb), .o_cur_ok(i_cur_ok)
    );

    always #10 i_ref_clk = ~i_ref_clk;

    task automatic test_done;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    // whole run is about 55000 cycles
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (o_pass === 1'b1 || o_fail === 1'b1) saw_done <= 1'b1;
        if (cyc == 70000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk

    // trip wins over override; a block without controllers takes its default
    function automatic logic [63:0] exp_out();
        logic [NPTS-1:0] v;
        logic [63:0] r;
        v = (i_out_cmd & ~i_manual_ovr & ~i_manual_trip) | (i_norm_energized & i_manual_ovr
            & ~i_manual_trip) | (~i_norm_energized & i_manual_trip);
        for (int b = 0; b < NBLK; b++) r[b*NPTS +: NPTS] = i_blk_comm_lost[b] ? i_default_state : v;
        return r;
    endfunction : exp_out

    initial begin
        void'($urandom(32'h35D2));
        repeat (5) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        for (int k = 0; k < 60; k++) begin
            i_out_cmd = 16'($urandom);
            i_norm_energized = 16'($urandom);
            i_default_state = 16'($urandom);
            i_manual_trip = (k < 30) ? 16'($urandom & $urandom) : 16'h0000;
            i_manual_ovr = (k < 30) ? 16'($urandom & $urandom) : 16'h0000;
            i_blk_comm_lost = (k < 30) ? 4'h0 : 4'($urandom);
            i_blk_state = {4{i_out_cmd}};
            e = exp_out();
            @(negedge i_ref_clk);
            chk(o_blk_out, e);
            chk(o_load_on, (e[15:0] | e[31:16]) & (e[47:32] | e[63:48]));
        end
        i_blk_comm_lost = 4'h0;
        // each kind of unmet precondition in turn
        for (int k = 0; k < 5; k++) begin
            i_blk_online = (k == 0) ? 4'hB : 4'hF;
            i_blk_override = (k == 1) ? 4'h4 : 4'h0;
            i_force = (k == 2) ? 16'h0100 : 16'h0000;
            i_hw_fault = (k == 3) ? 16'h8000 : 16'h0000;
            i_blk_state = {4{i_out_cmd}} ^ ((k == 4) ? 64'h0000_0000_0020_0000 : 64'h0);
            repeat (3) @(negedge i_ref_clk);
            chk(o_shutdown, k == 0);
            i_test_start = 1'b1;
            @(negedge i_ref_clk);
            i_test_start = 1'b0;
            chk(o_busy, 1'b1);
            @(negedge i_ref_clk);
            chk({o_skip, o_busy, o_pass, o_fail}, 4'h8);
        end
        i_blk_online = 4'hF;
        i_out_cmd = 16'h00FF;
        i_blk_state = {4{i_out_cmd}};
        // points 8..15 dark, 0..7 lit; one pair per lit point
        for (int k = 0; k < 20; k++) begin
            i_blk_noload = 64'h0;
            repeat (2) @(negedge i_ref_clk);
            p = 8 + int'(3'($urandom));
            q = int'(3'($urandom));
            m = 4'($urandom % 15 + 1);
            m2 = 4'($urandom) & (($urandom % 2) ? 4'h3 : 4'hC);
            for (int b = 0; b < NBLK; b++) i_blk_noload[b][p] = m[b];
            for (int b = 0; b < NBLK; b++) i_blk_noload[b][q] = m2[b];
            repeat (3) @(negedge i_ref_clk);
            f = (m2 == 4'h3 || m2 == 4'hC);
            chk(o_nl_fault, (16'h0001 << p) | (16'(f) << q));
            chk(o_nl_loc[p], m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3);
            if (f) chk(o_nl_loc[q], (m2 == 4'h3) ? 2'h1 : 2'h3);
        end
        i_blk_noload = 64'h0000_0000_0008_0000;
        repeat (3) @(negedge i_ref_clk);
        i_blk_noload = 64'h0000_0000_0008_0008;
        repeat (3) @(negedge i_ref_clk);
        chk(o_nl_loc[3], 2'h0);
        i_blk_noload = 64'h0;
        i_out_cmd = 16'h0002;
        i_blk_state = {4{i_out_cmd}};
        @(negedge i_ref_clk);
        i_test_start = 1'b1;
        @(negedge i_ref_clk);
        i_test_start = 1'b0;
        n = 0;
        while (o_blk_out[0][0] !== 1'b1 && n < 100) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk({o_blk_out[3][0], o_blk_out[2][0], o_blk_out[1][0], o_blk_out[0][0]}, 4'hF);
        n = 0;
        while (o_blk_out[0][0] === 1'b1 && n < 60000) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk(n >= (T_32 - 1) * TICK_CYCLES && n <= T_32 * TICK_CYCLES, 1'b1);
        n = 0;
        while (o_blk_out[0][1] !== 1'b0 && n < 100) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk({o_blk_out[3][1], o_blk_out[2][1], o_blk_out[1][1], o_blk_out[0][1]}, 4'h0);
        repeat (2500) @(negedge i_ref_clk);
        i_out_cmd = 16'h0022;
        i_blk_state = {4{i_out_cmd}};
        n = 0;
        while (o_busy !== 1'b0 && n < 20) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk({o_busy, saw_done, o_fault_mask}, 18'h0);
        // 16-circuit lit point: first off pulse, aborted long before it ends
        i_is_32ckt = 1'b0;
        i_out_cmd = 16'h0001;
        i_blk_state = {4{i_out_cmd}};
        repeat (2) @(negedge i_ref_clk);
        chk(o_blk_out[0][0], 1'b1);
        i_test_start = 1'b1; // only the group start, never a block's own pulse
        @(negedge i_ref_clk);
        i_test_start = 1'b0;
        repeat (2500) @(negedge i_ref_clk);
        chk(o_busy, 1'b1);
        chk({o_blk_out[3][0], o_blk_out[2][0], o_blk_out[1][0], o_blk_out[0][0]}, 4'h0);
        i_out_cmd = 16'h0003;
        i_blk_state = {4{i_out_cmd}};
        repeat (4) @(negedge i_ref_clk);
        chk({o_busy, saw_done, o_fault_mask, o_blk_out[0]}, 34'h0_0000_0003);
        test_done();
    end
endmodule : redundant_output_pulse_autotest_tb_top
